// ---- hw/mac_qsi_pkg.sv ----
// Constants and types for the MAC queue pointer, receive status and interrupt block
// Notes on behaviour
// - Pointer loads software base, descriptors fetched there
// - Index steps per buffer, wraps at 1024/wrap
// - Pointer write ignored while transmit is active
// - Pointer read gives first buffer of frame
// - Receive flags clear on written one only
// - No-buffer flag sets on every failed fetch
// - After failure, reread descriptor each new frame
// - Frame-received flag sets when frame stored
// - Overrun flag on late grant/bus error, recover buffer
// - Management done sets bit 0; read clears all
// - Receive complete sets bit 1 per stored frame
// - Used bit read sets bit 2 rx, 3 tx
// - Underrun bit 4: late, error, mid-frame, pointer write
// - Buffers exhausted mid-frame sets bit 6
// - Transmit complete sets bit 7 per frame
// - Receive overrun status sets bit 10
// - DMA bus error sets bit 11
// - Valid pause frame sets bit 12
// - Pause counter reaching zero sets bit 13
// - Enable-set write unmasks written sources
// - Enable-clear write masks written sources
// - Mask register shows which sources are masked
package mac_qsi_pkg;

    // Register byte offsets on the Avalon slave
    localparam logic [7:0] TBQP_OFFSET = 8'h1c;
    localparam logic [7:0] RSR_OFFSET  = 8'h20;
    localparam logic [7:0] ISR_OFFSET  = 8'h24;
    localparam logic [7:0] IER_OFFSET  = 8'h28;
    localparam logic [7:0] IDR_OFFSET  = 8'h2c;
    localparam logic [7:0] IMR_OFFSET  = 8'h30;

    // Receive status bit positions
    localparam int RX_NO_BUFFER_BIT     = 0;
    localparam int FRAME_RECEIVED_BIT   = 1;
    localparam int RX_OVERRUN_BIT       = 2;

    // Interrupt status bit positions
    localparam int MGMT_DONE_BIT        = 0;
    localparam int RX_COMPLETE_BIT      = 1;
    localparam int RX_USED_BIT          = 2;
    localparam int TX_USED_BIT          = 3;
    localparam int TX_UNDERRUN_BIT      = 4;
    localparam int RETRY_LIMIT_BIT      = 5;
    localparam int TX_EXHAUSTED_BIT     = 6;
    localparam int TX_COMPLETE_BIT      = 7;
    localparam int RX_OVERRUN_IRQ_BIT   = 10;
    localparam int BUS_ERROR_BIT        = 11;
    localparam int PAUSE_RECEIVED_BIT   = 12;
    localparam int PAUSE_ZERO_BIT       = 13;

    // Implemented bits and reset values
    localparam logic [31:0] IRQ_IMPLEMENTED = 32'h0000_3cff;
    localparam logic [31:0] RSR_IMPLEMENTED = 32'h0000_0007;
    localparam logic [31:0] TBQP_WRITABLE   = 32'hffff_fffe;
    localparam logic [31:0] TBQP_RESET      = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET      = 32'h0000_3cff;
    localparam logic [9:0]  LAST_INDEX      = 10'h3ff;

    // Event strobes from the rest of the MAC, one-cycle pulses
    typedef struct packed {
        logic mgmt_done;
        logic rx_stored;
        logic rx_used_bit;
        logic rx_no_buffer;
        logic rx_late_grant;
        logic rx_bus_error;
        logic tx_used_bit;
        logic tx_late_fetch;
        logic tx_bus_error;
        logic tx_used_mid_frame;
        logic retry_limit;
        logic tx_exhausted;
        logic tx_complete;
        logic pause_received;
    } mac_event_type;

    // Transmit DMA buffer progress
    typedef struct packed {
        logic buffer_done;
        logic wrap;
    } tx_progress_type;

endpackage : mac_qsi_pkg

// ---- hw/mac_queue_status_irq.sv ----
// Transmit queue pointer, receive status, interrupt status and mask registers
module mac_queue_status_irq
    import mac_qsi_pkg::*;
(
    // Clock and reset
    input  wire logic            ref_clk_i,
    input  wire logic            reset_n_i,
    // Avalon-MM slave
    input  wire logic [7:0]      avs_address_i,
    input  wire logic            avs_read_i,
    input  wire logic            avs_write_i,
    input  wire logic [31:0]     avs_writedata_i,
    input  wire logic [3:0]      avs_byteenable_i,
    output logic [31:0]          avs_readdata_o,
    output logic                 avs_waitrequest_o,
    // MAC status and events
    input  wire logic            transmit_active_bit_i,
    input  wire mac_event_type   mac_event_i,
    input  wire logic [15:0]     pause_time_i,
    // Transmit DMA
    input  wire tx_progress_type tx_progress_i,
    output logic [31:0]          tx_desc_addr_o,
    // Receive DMA
    input  wire logic            rx_frame_start_i,
    input  wire logic            rx_fetch_ok_i,
    output logic                 rx_desc_reread_o,
    output logic                 rx_buffer_recover_o,
    // Interrupt
    output logic                 irq_o
);

    // Bus handshake state
    logic        ack;
    logic [31:0] read_word;
    logic [31:0] wmask;

    // Registers
    logic [31:0] tx_descriptor_queue_pointer;
    logic [9:0]  tx_index;
    logic [9:0]  frame_index;
    logic [31:0] receive_status_flags;
    logic [31:0] interrupt_status_flags;
    logic [31:0] irq_mask;
    logic        reread_pending;
    logic [15:0] pause_time_prev;

    // Next values
    logic [31:0] next_rsr;
    logic [31:0] next_isr;

    // Byte-lane mask for writes
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++) begin : g_lane
            assign wmask[lane*8 +: 8] = {8{avs_byteenable_i[lane]}};
        end
    endgenerate

    // Handshake: one wait cycle, then the request is taken
    wire req       = avs_read_i | avs_write_i;
    wire first     = req & ~ack;
    wire wr_taken  = avs_write_i & ack;
    wire rd_first  = avs_read_i & ~ack;
    wire [31:0] wd = avs_writedata_i & wmask;
    assign avs_waitrequest_o = first;

    // Address decode
    wire sel_tbqp = (avs_address_i == TBQP_OFFSET);
    wire sel_rsr  = (avs_address_i == RSR_OFFSET);
    wire sel_isr  = (avs_address_i == ISR_OFFSET);
    wire sel_ier  = (avs_address_i == IER_OFFSET);
    wire sel_idr  = (avs_address_i == IDR_OFFSET);
    wire sel_imr  = (avs_address_i == IMR_OFFSET);

    // Write strobes
    wire tbqp_write  = wr_taken & sel_tbqp & ~transmit_active_bit_i;
    wire rsr_write   = wr_taken & sel_rsr;
    wire ier_write   = wr_taken & sel_ier;
    wire idr_write   = wr_taken & sel_idr;
    wire isr_rd_clr  = rd_first & sel_isr;

    // Descriptor addresses from base and indices
    wire [31:0] cur_addr   = tx_descriptor_queue_pointer + {19'h0, tx_index, 3'h0};
    wire [31:0] frame_addr = tx_descriptor_queue_pointer + {19'h0, frame_index, 3'h0};
    assign tx_desc_addr_o = cur_addr;

    // Read data select, unmapped reads as zero
    assign read_word = sel_tbqp ? frame_addr :
                       sel_rsr  ? receive_status_flags :
                       sel_isr  ? interrupt_status_flags :
                       sel_imr  ? irq_mask :
                       32'h0000_0000;

    // Event conditions
    wire rx_overrun_set = mac_event_i.rx_late_grant | mac_event_i.rx_bus_error;
    wire pause_zero     = (pause_time_prev != 16'h0000) &&
                          (pause_time_i == 16'h0000);
    wire any_bus_error  = mac_event_i.rx_bus_error | mac_event_i.tx_bus_error;
    wire tx_underrun    = mac_event_i.tx_late_fetch | mac_event_i.tx_bus_error |
                          mac_event_i.tx_used_mid_frame | tbqp_write;

    // Receive status set vector
    logic [31:0] rsr_set;
    always_comb begin
        rsr_set                     = 32'h0000_0000;
        rsr_set[RX_NO_BUFFER_BIT]   = mac_event_i.rx_no_buffer;
        rsr_set[FRAME_RECEIVED_BIT] = mac_event_i.rx_stored;
        rsr_set[RX_OVERRUN_BIT]     = rx_overrun_set;
    end

    // Interrupt status set vector
    logic [31:0] isr_set;
    always_comb begin
        isr_set                     = 32'h0000_0000;
        isr_set[MGMT_DONE_BIT]      = mac_event_i.mgmt_done;
        isr_set[RX_COMPLETE_BIT]    = mac_event_i.rx_stored;
        isr_set[RX_USED_BIT]        = mac_event_i.rx_used_bit;
        isr_set[TX_USED_BIT]        = mac_event_i.tx_used_bit;
        isr_set[TX_UNDERRUN_BIT]    = tx_underrun;
        isr_set[RETRY_LIMIT_BIT]    = mac_event_i.retry_limit;
        isr_set[TX_EXHAUSTED_BIT]   = mac_event_i.tx_exhausted;
        isr_set[TX_COMPLETE_BIT]    = mac_event_i.tx_complete;
        isr_set[RX_OVERRUN_IRQ_BIT] = rx_overrun_set;
        isr_set[BUS_ERROR_BIT]      = any_bus_error;
        isr_set[PAUSE_RECEIVED_BIT] = mac_event_i.pause_received;
        isr_set[PAUSE_ZERO_BIT]     = pause_zero;
    end

    // Flag updates: a set in the clearing cycle wins
    assign next_rsr = ((receive_status_flags & ~(rsr_write ? wd : 32'h0)) | rsr_set)
                      & RSR_IMPLEMENTED;
    assign next_isr = ((isr_rd_clr ? 32'h0 : interrupt_status_flags) | isr_set)
                      & IRQ_IMPLEMENTED;

    // Index stepping with wrap at the last entry or the wrap bit
    wire       tx_step    = tx_progress_i.buffer_done;
    wire       tx_wrap    = tx_progress_i.wrap | (tx_index == LAST_INDEX);
    wire [9:0] next_index = tx_wrap ? 10'h000 : tx_index + 10'h001;

    // Interrupt output from flag and mask flops
    assign irq_o = |(interrupt_status_flags & ~irq_mask);

    // Reread request at each frame start while the last fetch failed
    assign rx_desc_reread_o = rx_frame_start_i & reread_pending;

    // Bus handshake and read data
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ack            <= 1'b0;
            avs_readdata_o <= 32'h0000_0000;
        end else begin
            ack <= first;
            if (rd_first) begin
                avs_readdata_o <= read_word;
            end
        end
    end

    // Transmit queue pointer base
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_descriptor_queue_pointer <= TBQP_RESET;
        end else if (tbqp_write) begin
            tx_descriptor_queue_pointer <= ((tx_descriptor_queue_pointer & ~wmask) | wd)
                                           & TBQP_WRITABLE;
        end
    end

    // Current and frame-start indices
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_index    <= 10'h000;
            frame_index <= 10'h000;
        end else if (tbqp_write) begin
            tx_index    <= 10'h000;
            frame_index <= 10'h000;
        end else begin
            if (tx_step) begin
                tx_index <= next_index;
            end
            if (mac_event_i.tx_complete) begin
                frame_index <= tx_step ? next_index : tx_index;
            end
        end
    end

    // Status flags
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            receive_status_flags   <= 32'h0000_0000;
            interrupt_status_flags <= 32'h0000_0000;
        end else begin
            receive_status_flags   <= next_rsr;
            interrupt_status_flags <= next_isr;
        end
    end

    // Interrupt mask, set means masked
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_mask <= MASK_RESET;
        end else if (ier_write) begin
            irq_mask <= irq_mask & ~(wd & IRQ_IMPLEMENTED);
        end else if (idr_write) begin
            irq_mask <= irq_mask | (wd & IRQ_IMPLEMENTED);
        end
    end

    // Receive fetch failure tracking, buffer recovery and pause history
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reread_pending      <= 1'b0;
            rx_buffer_recover_o <= 1'b0;
            pause_time_prev     <= 16'h0000;
        end else begin
            if (mac_event_i.rx_no_buffer) begin
                reread_pending <= 1'b1;
            end else if (rx_fetch_ok_i) begin
                reread_pending <= 1'b0;
            end
            rx_buffer_recover_o <= rx_overrun_set;
            pause_time_prev     <= pause_time_i;
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    a_tbqp_locked: assert property (
        (wr_taken && sel_tbqp && transmit_active_bit_i) |=> $stable(tx_descriptor_queue_pointer))
        else $error("pointer changed while transmit active");

    a_underrun_on_ptr: assert property (
        tbqp_write |=> interrupt_status_flags[TX_UNDERRUN_BIT] && tx_index == 10'h000)
        else $error("pointer write did not flag underrun");

    a_rsr_no_set: assert property (
        ((receive_status_flags & ~$past(receive_status_flags)) & ~$past(rsr_set)) == 32'h0)
        else $error("receive flag set without an event");

    a_rsr_w1c_clear: assert property (
        (rsr_write && wd[FRAME_RECEIVED_BIT] && !mac_event_i.rx_stored)
        |=> !receive_status_flags[FRAME_RECEIVED_BIT])
        else $error("frame received flag not cleared");

    a_no_buffer_fail: assert property (
        mac_event_i.rx_no_buffer |=> receive_status_flags[RX_NO_BUFFER_BIT] && reread_pending)
        else $error("no-buffer flag missed");

    a_reread_frame: assert property (
        (mac_event_i.rx_no_buffer ##1 (!rx_fetch_ok_i throughout (1'b1 ##[0:7] rx_frame_start_i)))
        |-> rx_desc_reread_o)
        else $error("descriptor not reread after failure");

    a_isr_read_clr: assert property (
        (isr_rd_clr && isr_set == 32'h0)
        |=> interrupt_status_flags == 32'h0 && !avs_waitrequest_o)
        else $error("status not cleared by read");

    a_overrun_both: assert property (
        rx_overrun_set |=> interrupt_status_flags[RX_OVERRUN_IRQ_BIT]
                        && receive_status_flags[RX_OVERRUN_BIT] && rx_buffer_recover_o)
        else $error("overrun not flagged");

    a_ptr_wrap: assert property (
        (tx_step && tx_index == LAST_INDEX && !tbqp_write) |=> tx_index == 10'h000)
        else $error("index did not wrap");

    a_mask_disable: assert property (
        (idr_write && wd[MGMT_DONE_BIT]) |=> irq_mask[MGMT_DONE_BIT])
        else $error("disable write did not mask");

    a_irq_enable: assert property (
        (ier_write && wd[MGMT_DONE_BIT] && interrupt_status_flags[MGMT_DONE_BIT]) |=> irq_o)
        else $error("enabled source did not raise interrupt");

    a_ptr_load_base: assert property (
        tbqp_write
        |=> tx_desc_addr_o == tx_descriptor_queue_pointer)
        else $error("descriptor fetch not at base");

    a_index_step: assert property (
        (tx_step && !tx_wrap && !tbqp_write)
        |=> tx_index == $past(tx_index) + 10'h001)
        else $error("index did not step by one");

    a_index_wrap_bit: assert property (
        (tx_step && tx_progress_i.wrap && !tbqp_write)
        |=> tx_index == 10'h000)
        else $error("wrap bit did not return index");

    a_index_hold: assert property (
        (!tx_step && !tbqp_write)
        |=> $stable(tx_index))
        else $error("index moved without a buffer");

    a_frame_hold: assert property (
        (!mac_event_i.tx_complete && !tbqp_write)
        |=> $stable(frame_index))
        else $error("frame start moved without completion");

    a_frame_step: assert property (
        (mac_event_i.tx_complete && !tx_step && !tbqp_write)
        |=> frame_index == $past(tx_index))
        else $error("frame start not advanced");

    a_rsr_clear_overrun: assert property (
        (rsr_write && wd[RX_OVERRUN_BIT] && !rx_overrun_set)
        |=> !receive_status_flags[RX_OVERRUN_BIT])
        else $error("overrun flag not cleared");

    a_rsr_keep_set: assert property (
        (rsr_write && !wd[RX_NO_BUFFER_BIT] && receive_status_flags[RX_NO_BUFFER_BIT])
        |=> receive_status_flags[RX_NO_BUFFER_BIT])
        else $error("zero write cleared a flag");

    a_frame_stored: assert property (
        mac_event_i.rx_stored
        |=> receive_status_flags[FRAME_RECEIVED_BIT] && interrupt_status_flags[RX_COMPLETE_BIT])
        else $error("stored frame not flagged");

    a_mgmt_done_set: assert property (
        mac_event_i.mgmt_done
        |=> interrupt_status_flags[MGMT_DONE_BIT])
        else $error("management done not flagged");

    a_rx_used_set: assert property (
        mac_event_i.rx_used_bit
        |=> interrupt_status_flags[RX_USED_BIT])
        else $error("receive used bit not flagged");

    a_tx_used_set: assert property (
        mac_event_i.tx_used_bit
        |=> interrupt_status_flags[TX_USED_BIT])
        else $error("transmit used bit not flagged");

    a_underrun_events: assert property (
        (mac_event_i.tx_late_fetch || mac_event_i.tx_used_mid_frame || mac_event_i.tx_bus_error)
        |=> interrupt_status_flags[TX_UNDERRUN_BIT])
        else $error("underrun not flagged");

    a_exhausted_set: assert property (
        mac_event_i.tx_exhausted
        |=> interrupt_status_flags[TX_EXHAUSTED_BIT])
        else $error("buffers exhausted not flagged");

    a_tx_done_set: assert property (
        mac_event_i.tx_complete
        |=> interrupt_status_flags[TX_COMPLETE_BIT])
        else $error("transmit complete not flagged");

    a_bus_error_set: assert property (
        (mac_event_i.rx_bus_error || mac_event_i.tx_bus_error)
        |=> interrupt_status_flags[BUS_ERROR_BIT])
        else $error("bus error not flagged");

    a_pause_frame_set: assert property (
        mac_event_i.pause_received
        |=> interrupt_status_flags[PAUSE_RECEIVED_BIT])
        else $error("pause frame not flagged");

    a_pause_zero_set: assert property (
        (pause_time_i == 16'h0000) && ($past(pause_time_i) != 16'h0000)
        |=> interrupt_status_flags[PAUSE_ZERO_BIT])
        else $error("pause zero not flagged");

    a_isr_no_set: assert property (
        ((interrupt_status_flags & ~$past(interrupt_status_flags))
         & ~$past(isr_set)) == 32'h0)
        else $error("interrupt flag set without an event");

    a_mask_enable: assert property (
        (ier_write && wd[MGMT_DONE_BIT])
        |=> !irq_mask[MGMT_DONE_BIT])
        else $error("enable write did not unmask");

    a_mask_readback: assert property (
        (rd_first && sel_imr)
        |=> avs_readdata_o == $past(irq_mask))
        else $error("mask read returned wrong value");

endmodule // mac_queue_status_irq

// ---- sim/mac_side_model.sv ----
// MAC-side model: event strobes, transmit buffer progress, pause counter
module mac_side_model
    import mac_qsi_pkg::*;
(
    // Clock and reset
    input  wire logic            ref_clk_i,
    input  wire logic            reset_n_i,
    // Requests from the bench
    input  wire mac_event_type   ev_req_i,
    input  wire tx_progress_type buf_req_i,
    input  wire logic            pause_load_i,
    input  wire logic [15:0]     pause_val_i,
    // Towards the block
    output mac_event_type        mac_event_o,
    output tx_progress_type      tx_progress_o,
    output logic [15:0]          pause_time_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Strobes leave as one-cycle pulses; the pause counter runs down to zero
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mac_event_o   <= '0;
            tx_progress_o <= '0;
            pause_time_o  <= 16'h0000;
        end else begin
            mac_event_o   <= ev_req_i;
            tx_progress_o <= buf_req_i;
            if (pause_load_i) begin
                pause_time_o <= pause_val_i;
            end else if (pause_time_o != 16'h0000) begin
                pause_time_o <= pause_time_o - 16'h0001;
            end
        end
    end
endmodule // mac_side_model

// ---- sim/tb.sv ----
// Self-checking bench for the queue pointer, status and interrupt block
module tb
    import mac_qsi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic            ref_clk_i = 1'b0;
    logic            reset_n_i = 1'b0;
    logic [7:0]      addr      = 8'h00;
    logic            rd_en     = 1'b0;
    logic            wr_en     = 1'b0;
    logic [31:0]     wdata     = 32'h0;
    logic [31:0]     rdata;
    logic            wait_req;
    logic            tx_active = 1'b0;
    logic            frame_st  = 1'b0;
    logic            fetch_ok  = 1'b0;
    mac_event_type   ev_req    = '0;
    mac_event_type   events;
    tx_progress_type buf_req   = '0;
    tx_progress_type progress;
    logic            p_load    = 1'b0;
    logic [15:0]     p_val     = 16'h0000;
    logic [15:0]     p_time;
    logic [31:0]     desc_addr;
    logic            reread;
    logic            recover;
    logic            irq;
    logic [31:0]     rd;
    int              mismatches = 0;
    int              checks = 0;
    int              cycles = 0;
    int              recov = 0;
    localparam logic [31:0] ISR_EXP [14] = '{32'h1, 32'h2, 32'h4, 32'h0, 32'h400,
        32'hc00, 32'h8, 32'h10, 32'h810, 32'h10, 32'h20, 32'h40, 32'h80, 32'h1000};

    mac_queue_status_irq dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
        .avs_address_i(addr), .avs_read_i(rd_en), .avs_write_i(wr_en),
        .avs_writedata_i(wdata), .avs_byteenable_i(4'hf), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wait_req), .transmit_active_bit_i(tx_active),
        .mac_event_i(events), .pause_time_i(p_time), .tx_progress_i(progress),
        .tx_desc_addr_o(desc_addr), .rx_frame_start_i(frame_st),
        .rx_fetch_ok_i(fetch_ok), .rx_desc_reread_o(reread),
        .rx_buffer_recover_o(recover), .irq_o(irq));
    mac_side_model far (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
        .ev_req_i(ev_req), .buf_req_i(buf_req), .pause_load_i(p_load),
        .pause_val_i(p_val), .mac_event_o(events), .tx_progress_o(progress),
        .pause_time_o(p_time));

    // 250 MHz clock
    always #2 ref_clk_i = ~ref_clk_i;

    // Hang ceiling and count of recovery pulses
    always @(posedge ref_clk_i) begin
        cycles++;
        if (recover === 1'b1) recov++;
        if (cycles == 20000) begin
            mismatches++;
            results();
        end
    end

    task automatic results();
        if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    // One Avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        addr  <= a;
        wdata <= d;
        wr_en <= w;
        rd_en <= !w;
        do begin
            @(posedge ref_clk_i);
        end while (wait_req !== 1'b0);
        rd = rdata;
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        @(posedge ref_clk_i);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    task automatic pulse(input logic [13:0] e);
        ev_req <= e;
        @(posedge ref_clk_i);
        ev_req <= '0;
        repeat (3) @(posedge ref_clk_i);
    endtask

    task automatic bufs(input int n, input logic w);
        buf_req <= {1'b1, w};
        repeat (n) @(posedge ref_clk_i);
        buf_req <= '0;
        repeat (3) @(posedge ref_clk_i);
    endtask

    task automatic t_reset();
        rchk(IMR_OFFSET, MASK_RESET);
        rchk(TBQP_OFFSET, TBQP_RESET);
        rchk(8'h04, 32'h0);
        chk(32'(irq), 32'h0);
    endtask

    task automatic t_pointer();
        rchk(ISR_OFFSET, 32'h0);
        bus(1'b1, TBQP_OFFSET, 32'h1000);
        rchk(TBQP_OFFSET, 32'h1000);
        chk(desc_addr, 32'h1000);
        rchk(ISR_OFFSET, 32'h10);
        tx_active <= 1'b1;
        bus(1'b1, TBQP_OFFSET, 32'h2000);
        tx_active <= 1'b0;
        rchk(TBQP_OFFSET, 32'h1000);
        rchk(ISR_OFFSET, 32'h0);
    endtask

    task automatic t_progress();
        bufs(3, 1'b0);
        chk(desc_addr, 32'h1018);
        rchk(TBQP_OFFSET, 32'h1000);
        pulse(14'h0002);
        rchk(TBQP_OFFSET, 32'h1018);
        rchk(ISR_OFFSET, 32'h80);
        bufs(1, 1'b1);
        chk(desc_addr, 32'h1000);
        bufs(1023, 1'b0);
        chk(desc_addr, 32'h2ff8);
        bufs(1, 1'b0);
        chk(desc_addr, 32'h1000);
    endtask

    task automatic t_rsr();
        int n;
        pulse(14'h0400);
        frame_st <= 1'b1;
        @(negedge ref_clk_i);
        chk(32'(reread), 32'h1);
        @(posedge ref_clk_i);
        frame_st <= 1'b0;
        fetch_ok <= 1'b1;
        @(posedge ref_clk_i);
        fetch_ok <= 1'b0;
        frame_st <= 1'b1;
        @(negedge ref_clk_i);
        chk(32'(reread), 32'h0);
        @(posedge ref_clk_i);
        frame_st <= 1'b0;
        pulse(14'h1000);
        n = recov;
        pulse(14'h0200);
        chk(recov - n, 32'h1);
        rchk(RSR_OFFSET, 32'h7);
        bus(1'b1, RSR_OFFSET, 32'h0);
        rchk(RSR_OFFSET, 32'h7);
        bus(1'b1, RSR_OFFSET, 32'h2);
        rchk(RSR_OFFSET, 32'h5);
        bus(1'b1, RSR_OFFSET, 32'h1);
        pulse(14'h0400);
        rchk(RSR_OFFSET, 32'h5);
        bus(1'b1, RSR_OFFSET, 32'h7);
        rchk(RSR_OFFSET, 32'h0);
        rchk(ISR_OFFSET, 32'h402);
    endtask

    task automatic t_isr();
        for (int i = 0; i < 14; i++) begin
            pulse(14'h2000 >> i);
            rchk(ISR_OFFSET, ISR_EXP[i]);
            rchk(ISR_OFFSET, 32'h0);
        end
        p_val  <= 16'h0003;
        p_load <= 1'b1;
        @(posedge ref_clk_i);
        p_load <= 1'b0;
        repeat (8) @(posedge ref_clk_i);
        rchk(ISR_OFFSET, 32'h2000);
    endtask

    task automatic t_mask();
        bus(1'b1, IER_OFFSET, 32'h3cff);
        rchk(IMR_OFFSET, 32'h0);
        pulse(14'h2000);
        chk(32'(irq), 32'h1);
        bus(1'b1, IDR_OFFSET, 32'h1);
        rchk(IMR_OFFSET, 32'h1);
        chk(32'(irq), 32'h0);
        bus(1'b1, ISR_OFFSET, 32'h0);
        bus(1'b1, IER_OFFSET, 32'h1);
        chk(32'(irq), 32'h1);
        rchk(ISR_OFFSET, 32'h1);
        chk(32'(irq), 32'h0);
    endtask

    // Reset, then the scenarios in turn
    initial begin
        repeat (8) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        @(posedge ref_clk_i);
        t_reset();
        t_pointer();
        t_progress();
        t_rsr();
        t_isr();
        t_mask();
        results();
    end
endmodule // tb
